// file: shared/irq_ctrl_pkg.sv
/*
 * Package for the six-source vectored interrupt controller: register
 * addresses, bit positions, reset values, vectors and carrier structs.
 * Assumes one instruction-cycle clock and a core-side special register port.
 */
`default_nettype none
package irq_ctrl_pkg;
   localparam logic [7:0] CTRL0_ADDR = 8'h0B;
   localparam logic [7:0] CTRL1_ADDR = 8'h1E;
   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam int GLOBAL_EN_BIT = 0;
   localparam int EN_LO_BIT = 1;
   localparam int FLAG0_LO_BIT = 4;
   localparam int EN1_LO_BIT = 0;
   localparam int FLAG1_LO_BIT = 4;
   localparam int NUM_SRC = 6;
   localparam int STACK_DEPTH = 6;
   localparam logic [2:0] STACK_DEPTH_CNT = 3'h6;
   localparam int PC_W = 12;
   localparam logic [PC_W-1:0] VEC_EXT0 = 12'h004;
   localparam logic [PC_W-1:0] VEC_EXT1 = 12'h008;
   localparam logic [PC_W-1:0] VEC_TMR0 = 12'h00C;
   localparam logic [PC_W-1:0] VEC_TMR1 = 12'h010;
   localparam logic [PC_W-1:0] VEC_TICK = 12'h014;
   localparam logic [PC_W-1:0] VEC_CLKT = 12'h018;

   // Core register port: one access per instruction cycle
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Core sequencer events toward the stack
   typedef struct packed {
      logic call;
      logic ret;
      logic return_from_isr_instr;
      logic [PC_W-1:0] pc;
   } seq_req_t;

   // Periodic and overflow events, one-cycle pulses
   typedef struct packed {
      logic timer0_ovf;
      logic timer1_ovf;
      logic tick_tmo;
      logic clock_tick_tmo;
   } src_evt_t;

   typedef struct packed {
      logic ack;
      logic [PC_W-1:0] vector;
   } irq_ack_t;
endpackage : irq_ctrl_pkg
`default_nettype wire

// file: src/irq_return_stack.sv
/*
 * Return stack shared by calls and interrupt acknowledges.
 * Assumes the caller never pushes when full nor pops when empty.
 */
`default_nettype none
module irq_return_stack
   import irq_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // Push and pop
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [PC_W-1:0] push_data_i,
   // Status and data
   output logic [PC_W-1:0] top_o,
   output logic full_o,
   output logic [2:0] level_o
);
   typedef struct packed {
      logic [STACK_DEPTH-1:0][PC_W-1:0] mem;
      logic [2:0] sp;
      logic [PC_W-1:0] top;
   } stk_t;
   stk_t s, next_s;

   always_comb begin
      next_s = s;
      // A push and a pop in one cycle swap the top entry, so neither event is lost
      if (push_i && pop_i && s.sp != 3'h0) begin
         next_s.top = s.mem[s.sp - 3'h1];
         next_s.mem[s.sp - 3'h1] = push_data_i;
      end else if (push_i && s.sp != STACK_DEPTH_CNT) begin
         next_s.mem[s.sp] = push_data_i;
         next_s.sp = s.sp + 3'h1;
      end else if (pop_i && s.sp != 3'h0) begin
         next_s.sp = s.sp - 3'h1;
         next_s.top = s.mem[s.sp - 3'h1];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign top_o = s.top;
   assign full_o = (s.sp == STACK_DEPTH_CNT);
   assign level_o = s.sp;
endmodule : irq_return_stack
`default_nettype wire

// file: src/irq_vector_ctrl.sv
/*
 * Six-source vectored interrupt controller with its return stack.
 * Assumes the core raises one phase-two pulse per machine cycle, takes the
 * acknowledge as a call to the given vector in that same cycle, and uses
 * the register port for the two control registers.
 */
`default_nettype none
module irq_vector_ctrl
   import irq_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // Core register port
   input wire reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // Core sequencer
   input wire logic cycle_phase_two_pulse_i,
   input wire seq_req_t seq_req_i,
   output irq_ack_t irq_ack_o,
   output logic [PC_W-1:0] return_addr_o,
   output logic stack_full_o,
   // Interrupt sources
   input wire logic ext_irq_pin_a_i,
   input wire logic ext_irq_pin_b_i,
   input wire src_evt_t src_evt_i
);
   typedef struct packed {
      logic [1:0] pin_a_sync;
      logic [1:0] pin_b_sync;
      logic [1:0] pin_prev;
      logic global_irq_enable;
      logic [NUM_SRC-1:0] enable;
      logic [NUM_SRC-1:0] flag;
      logic [7:0] rdata;
   } st_t;
   st_t s, next_s;

   logic [NUM_SRC-1:0] hw_set;
   logic [NUM_SRC-1:0] pending;
   logic [NUM_SRC-1:0] grant;
   logic [PC_W-1:0] vec;
   logic ack;
   logic full;
   logic push;
   logic pop;
   logic [2:0] level;
   logic wr0;
   logic wr1;

   // Falling edge seen only after the second sync stage
   assign hw_set = {src_evt_i.clock_tick_tmo, src_evt_i.tick_tmo,
                    src_evt_i.timer1_ovf, src_evt_i.timer0_ovf,
                    s.pin_prev[1] & ~s.pin_b_sync[1], s.pin_prev[0] & ~s.pin_a_sync[1]};

   assign pending = s.flag & s.enable & {NUM_SRC{s.global_irq_enable & ~full}};

   always_comb begin
      grant = '0;
      vec = VEC_EXT0;
      if (pending[0]) begin
         grant[0] = 1'b1;
         vec = VEC_EXT0;
      end else if (pending[1]) begin
         grant[1] = 1'b1;
         vec = VEC_EXT1;
      end else if (pending[2]) begin
         grant[2] = 1'b1;
         vec = VEC_TMR0;
      end else if (pending[3]) begin
         grant[3] = 1'b1;
         vec = VEC_TMR1;
      end else if (pending[4]) begin
         grant[4] = 1'b1;
         vec = VEC_TICK;
      end else if (pending[5]) begin
         grant[5] = 1'b1;
         vec = VEC_CLKT;
      end
   end

   // Acknowledge only on the phase-two pulse; a core call in the same cycle yields
   assign ack = cycle_phase_two_pulse_i & (|pending) & ~seq_req_i.call;
   assign push = ack | seq_req_i.call;
   assign pop = seq_req_i.ret | seq_req_i.return_from_isr_instr;
   assign wr0 = reg_req_i.wr && reg_req_i.addr == CTRL0_ADDR;
   assign wr1 = reg_req_i.wr && reg_req_i.addr == CTRL1_ADDR;

   always_comb begin
      next_s = s;
      next_s.pin_a_sync = {s.pin_a_sync[0], ext_irq_pin_a_i};
      next_s.pin_b_sync = {s.pin_b_sync[0], ext_irq_pin_b_i};
      next_s.pin_prev = {s.pin_b_sync[1], s.pin_a_sync[1]};
      if (wr0) begin
         next_s.global_irq_enable = reg_req_i.wdata[GLOBAL_EN_BIT];
         next_s.enable[2:0] = reg_req_i.wdata[EN_LO_BIT +: 3];
         next_s.flag[2:0] = reg_req_i.wdata[FLAG0_LO_BIT +: 3];
      end
      if (wr1) begin
         next_s.enable[5:3] = reg_req_i.wdata[EN1_LO_BIT +: 3];
         next_s.flag[5:3] = reg_req_i.wdata[FLAG1_LO_BIT +: 3];
      end
      if (seq_req_i.return_from_isr_instr) begin
         next_s.global_irq_enable = 1'b1;
      end
      if (ack) begin
         next_s.global_irq_enable = 1'b0;
         next_s.flag = next_s.flag & ~grant;
      end
      next_s.flag = next_s.flag | hw_set;
      next_s.rdata = 8'h00;
      if (reg_req_i.addr == CTRL0_ADDR) begin
         next_s.rdata = {1'b0, next_s.flag[2:0], next_s.enable[2:0], next_s.global_irq_enable};
      end else if (reg_req_i.addr == CTRL1_ADDR) begin
         next_s.rdata = {1'b0, next_s.flag[5:3], 1'b0, next_s.enable[5:3]};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         s <= '0;
         s.pin_a_sync <= 2'h3;
         s.pin_b_sync <= 2'h3;
         s.pin_prev <= 2'h3;
         s.global_irq_enable <= CTRL0_RESET[GLOBAL_EN_BIT];
      end else begin
         s <= next_s;
      end
   end

   irq_return_stack u_stack (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .push_i(push),
      .pop_i(pop),
      .push_data_i(seq_req_i.pc),
      .top_o(return_addr_o),
      .full_o(full),
      .level_o(level)
   );

   assign irq_ack_o.ack = ack;
   assign irq_ack_o.vector = vec;
   assign stack_full_o = full;
   assign reg_rdata_o = s.rdata;

   // Assertions
   no_ack_masked_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !s.global_irq_enable |-> !ack) else $error("ack with global enable low");
   no_ack_full_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      full |-> !ack) else $error("ack with full stack");
   ack_phase_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack |-> cycle_phase_two_pulse_i) else $error("ack off phase two");
   ack_clears_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && !seq_req_i.return_from_isr_instr |=> !s.global_irq_enable) else $error("global enable not cleared");
   ext0_vector_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && pending[0] |-> vec == VEC_EXT0) else $error("ext0 vector wrong");
   prio_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && !pending[0] && pending[1] |-> vec == VEC_EXT1) else $error("priority wrong");
   return_from_isr_instr_sets_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      seq_req_i.return_from_isr_instr && !ack |=> s.global_irq_enable) else $error("return_from_isr_instr did not enable");
   set_wins_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      src_evt_i.timer0_ovf |=> s.flag[2]) else $error("timer0 flag lost");
   flag_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      s.flag[3] && !ack && !wr1 |=> s.flag[3]) else $error("flag dropped");
   push_level_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && !pop |=> level == $past(level) + 3'h1) else $error("stack not pushed");

   ext1_vector_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[1] |-> vec == VEC_EXT1)
      else $error("ext1 vector wrong");

   tmr0_vector_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[2] |-> vec == VEC_TMR0)
      else $error("timer0 vector wrong");

   tmr1_vector_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[3] |-> vec == VEC_TMR1)
      else $error("timer1 vector wrong");

   tick_vector_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[4] |-> vec == VEC_TICK)
      else $error("tick vector wrong");

   clkt_vector_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[5] |-> vec == VEC_CLKT)
      else $error("clock tick vector wrong");

   grant_onehot_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack |-> $onehot(grant))
      else $error("grant not one-hot");

   grant_pending_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack |-> (grant & pending) == grant)
      else $error("grant without pending");

   prio_tmr0_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && pending[2] && pending[1:0] == 2'h0 |-> grant[2])
      else $error("timer0 priority wrong");

   prio_tmr1_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && pending[3] && pending[2:0] == 3'h0 |-> grant[3])
      else $error("timer1 priority wrong");

   prio_tick_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && pending[4] && pending[3:0] == 4'h0 |-> grant[4])
      else $error("tick priority wrong");

   prio_clkt_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && pending[5] && pending[4:0] == 5'h0 |-> grant[5])
      else $error("clock tick priority wrong");

   ext0_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[0] && !hw_set[0] |=> !s.flag[0])
      else $error("ext0 flag not cleared");

   ext1_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[1] && !hw_set[1] |=> !s.flag[1])
      else $error("ext1 flag not cleared");

   tmr0_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[2] && !hw_set[2] |=> !s.flag[2])
      else $error("timer0 flag not cleared");

   tmr1_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[3] && !hw_set[3] |=> !s.flag[3])
      else $error("timer1 flag not cleared");

   tick_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[4] && !hw_set[4] |=> !s.flag[4])
      else $error("tick flag not cleared");

   clkt_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      ack && grant[5] && !hw_set[5] |=> !s.flag[5])
      else $error("clock tick flag not cleared");

   ext0_edge_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      hw_set[0] |=> s.flag[0])
      else $error("ext0 edge lost");

   ext1_edge_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      hw_set[1] |=> s.flag[1])
      else $error("ext1 edge lost");

   tmr1_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      src_evt_i.timer1_ovf |=> s.flag[3])
      else $error("timer1 flag lost");

   tick_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      src_evt_i.tick_tmo |=> s.flag[4])
      else $error("tick flag lost");

   clkt_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      src_evt_i.clock_tick_tmo |=> s.flag[5])
      else $error("clock tick flag lost");

   top_bit_zero_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !reg_rdata_o[7])
      else $error("bit seven not zero");

   ctrl1_bit3_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $past(reg_req_i.addr) == CTRL1_ADDR |-> !reg_rdata_o[3])
      else $error("ctrl1 bit three not zero");

   ctrl0_map_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $past(reg_req_i.addr) == CTRL0_ADDR |-> reg_rdata_o[6:0] == {s.flag[2:0], s.enable[2:0], s.global_irq_enable})
      else $error("ctrl0 read map wrong");

   ctrl1_map_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $past(reg_req_i.addr) == CTRL1_ADDR |-> reg_rdata_o[6:4] == s.flag[5:3] && reg_rdata_o[2:0] == s.enable[5:3])
      else $error("ctrl1 read map wrong");

   en0_write_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      wr0 |=> s.enable[2:0] == $past(reg_req_i.wdata[EN_LO_BIT +: 3]))
      else $error("ctrl0 enables not written");

   en1_write_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      wr1 |=> s.enable[5:3] == $past(reg_req_i.wdata[EN1_LO_BIT +: 3]))
      else $error("ctrl1 enables not written");

   en_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !wr0 && !wr1 |=> s.enable == $past(s.enable))
      else $error("enable changed without write");

   ret_keeps_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      seq_req_i.ret && !seq_req_i.return_from_isr_instr && !ack && !wr0 |=> s.global_irq_enable == $past(s.global_irq_enable))
      else $error("plain return changed enable");

   global_wr_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      wr0 && !ack && !seq_req_i.return_from_isr_instr |=> s.global_irq_enable == $past(reg_req_i.wdata[GLOBAL_EN_BIT]))
      else $error("global enable not written");

   call_yields_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      seq_req_i.call |-> !ack)
      else $error("ack during core call");

   pop_level_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      pop && !push && level != 3'h0 |=> level == $past(level) - 3'h1)
      else $error("stack not popped");

   push_pop_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      push && pop && level != 3'h0 |=> level == $past(level))
      else $error("swap changed level");

   level_max_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      level <= STACK_DEPTH_CNT)
      else $error("stack overflow");

   ext0_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      s.flag[0] && !(ack && grant[0]) && !wr0 |=> s.flag[0])
      else $error("ext0 flag dropped");

   ext1_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      s.flag[1] && !(ack && grant[1]) && !wr0 |=> s.flag[1])
      else $error("ext1 flag dropped");

   clkt_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      s.flag[5] && !(ack && grant[5]) && !wr1 |=> s.flag[5])
      else $error("clock tick flag dropped");

   // Coverage of the main scenarios
   cov_ack: cover property (@(posedge mclk_i) ack);
   cov_full: cover property (@(posedge mclk_i) full && |s.flag);
   cov_return_from_isr_instr: cover property (@(posedge mclk_i) ack ##[1:20] seq_req_i.return_from_isr_instr);
   cov_prio: cover property (@(posedge mclk_i) ack && pending[0] && pending[1]);
   cov_swen: cover property (@(posedge mclk_i) wr0 && reg_req_i.wdata[GLOBAL_EN_BIT] && |s.flag);
endmodule : irq_vector_ctrl
`default_nettype wire

// file: verif/core_phase_model.sv
/* Core-side model: raises one phase-two pulse per four-cycle machine cycle.
   Assumes the bench clock and the synchronous reset of the block. */
`default_nettype none
module core_phase_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // Phase pulse
   output logic phase_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt;
   // Sparse pulses, so requests really wait for the sampling point
   always_ff @(posedge mclk_i) begin
      cnt <= srst_i ? 2'h0 : cnt + 2'h1;
      phase_o <= !srst_i && cnt == 2'h3;
   end
endmodule : core_phase_model
`default_nettype wire

// file: verif/six_source_vectored_interrupt_ctrl_tb_top.sv
/* Self-checking bench for the vectored interrupt controller.
   Assumes the core phase model drives the phase-two pulse. */
`default_nettype none
module six_source_vectored_interrupt_ctrl_tb_top;
   import irq_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ph;
   logic pin_a = 1'b1;
   logic pin_b = 1'b1;
   reg_req_t req = '0;
   seq_req_t seq = '0;
   src_evt_t evt = '0;
   logic [7:0] rdata;
   irq_ack_t ack;
   logic [PC_W-1:0] raddr;
   logic full;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [PC_W-1:0] vt [6] = '{VEC_EXT0, VEC_EXT1, VEC_TMR0, VEC_TMR1, VEC_TICK, VEC_CLKT};
   always #50 mclk_i = ~mclk_i;
   core_phase_model phase_model (.mclk_i(mclk_i), .srst_i(srst_i), .phase_o(ph));
   irq_vector_ctrl dut (.mclk_i(mclk_i), .srst_i(srst_i), .reg_req_i(req), .reg_rdata_o(rdata),
      .cycle_phase_two_pulse_i(ph), .seq_req_i(seq), .irq_ack_o(ack), .return_addr_o(raddr),
      .stack_full_o(full), .ext_irq_pin_a_i(pin_a), .ext_irq_pin_b_i(pin_b), .src_evt_i(evt));
   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i) req <= '{1'b1, a, d};
      @(posedge mclk_i) req.wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i) req.addr <= a;
      @(posedge mclk_i) #1;
      chk(16'(rdata), 16'(e));
   endtask : rd
   task sq(input logic [2:0] k);
      @(posedge mclk_i) {seq.call, seq.ret, seq.return_from_isr_instr} <= k;
      @(posedge mclk_i) {seq.call, seq.ret, seq.return_from_isr_instr} <= 3'h0;
   endtask : sq
   task tmr0;
      @(posedge mclk_i) evt.timer0_ovf <= 1'b1;
      @(posedge mclk_i) evt.timer0_ovf <= 1'b0;
   endtask : tmr0
   task noack;
      repeat (8) begin
         @(negedge mclk_i);
         chk(16'(ack.ack), 16'h0000);
      end
   endtask : noack
   task wack(input logic [PC_W-1:0] v);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 20 && !hit; i++) begin
         @(negedge mclk_i);
         hit = (ack.ack === 1'b1);
      end
      if (!hit) begin
         n_mismatch++;
         test_done;
      end else begin
         chk(16'(ack.vector), 16'(v));
      end
   endtask : wack
   // Flags gather with the global enable off, then drain in priority order
   task prio_walk;
      wr(CTRL1_ADDR, 8'h07);
      wr(CTRL0_ADDR, 8'h0E);
      @(posedge mclk_i) evt <= 4'hF;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      @(posedge mclk_i) evt <= 4'h0;
      repeat (6) @(posedge mclk_i);
      rd(CTRL0_ADDR, 8'h7E);
      rd(CTRL1_ADDR, 8'h77);
      wr(CTRL0_ADDR, 8'h7F);
      wack(vt[0]);
      rd(CTRL0_ADDR, 8'h6E);
      for (int i = 1; i < 6; i++) begin
         sq(3'h1);
         #1 chk(16'(raddr), 16'(seq.pc));
         wack(vt[i]);
      end
   endtask : prio_walk
   // Plain return keeps service off; software re-enable and a full stack
   task ret_and_full;
      sq(3'h2);
      tmr0();
      noack();
      rd(CTRL0_ADDR, 8'h4E);
      wr(CTRL0_ADDR, 8'h4F);
      wack(VEC_TMR0);
      repeat (5) sq(3'h4);
      @(posedge mclk_i) #1 chk(16'(full), 16'h0001);
      tmr0();
      wr(CTRL0_ADDR, 8'h4F);
      noack();
      sq(3'h2);
      wack(VEC_TMR0);
   endtask : ret_and_full
   initial begin
      seq.pc <= 12'h5A3;
      repeat (5) @(posedge mclk_i);
      srst_i <= 1'b0;
      rd(CTRL0_ADDR, CTRL0_RESET);
      rd(CTRL1_ADDR, CTRL1_RESET);
      prio_walk();
      ret_and_full();
      test_done();
   end
endmodule : six_source_vectored_interrupt_ctrl_tb_top
`default_nettype wire
